// ==== pkg/pmt_pkg.sv ====
// constants for the power-management timer and sci status block
// Notes on behaviour
// - a 24-bit count advances once per 3.579545 MHz period in the working state
// - host bus reset or standby power-on reset clears the count, then counting resumes
// - count halts while the 14.31818 MHz reference stops, resumes from held value
// - any change of count bit 23 sets the rollover flag
// - with rollover sci enable set, the rollover flag also raises an sci
// - second timer byte reads count bits 15 to 8; writes do nothing
// - timer byte at offset a reads count bits 23 to 16, read-only
// - timer byte at offset b is reserved, read-only, holds no count bits
// - reading the lowest timer byte latches the two upper bytes coherently
// - status a at offset 0 mirrors eight sources read-only, cleared at source
// - status b at offset 1 mirrors mouse, keyboard, kbc port, mgmt bus read-only
// - status b bit 2 set by any infrared edge after the mux; write one clears
// - status b bit 3 set when button delay starts; write one clears
// - standby power-on reset clears status b bits 2 and 3
// - status b bits 6 and 7 always read zero
// - enable registers a and b select sources onto group sci; sci_irq_route_en routes it to irq pin
package pmt_pkg;
    localparam int          COUNT_W        = 24;
    localparam int          BYTE_W         = 8;
    localparam int          ADDR_W         = 4;
    // ***************************
    // timer rates
    // ***************************
    localparam int          REF_CLK_HZ     = 14318180;
    localparam int          PM_CLK_HZ      = 3579545;
    localparam int          REF_DIV        = REF_CLK_HZ / PM_CLK_HZ;
    localparam int          REF_DIV_W      = 2;
    // ***************************
    // power-management block offsets
    // ***************************
    localparam logic [3:0]  PM_CNT_LOW     = 4'h8;
    localparam logic [3:0]  PM_CNT_MID     = 4'h9;
    localparam logic [3:0]  PM_CNT_UPPER   = 4'ha;
    localparam logic [3:0]  PM_CNT_SPARE   = 4'hb;
    // ***************************
    // misc block offsets
    // ***************************
    localparam logic [3:0]  SCI_STS_A      = 4'h0;
    localparam logic [3:0]  SCI_STS_B      = 4'h1;
    localparam logic [3:0]  SCI_EN_A       = 4'h2;
    localparam logic [3:0]  SCI_EN_B       = 4'h3;
    // ***************************
    // status b fields
    // ***************************
    localparam int          STB_MOUSE      = 0;
    localparam int          STB_KBD        = 1;
    localparam int          STB_IR         = 2;
    localparam int          STB_BTN        = 3;
    localparam int          STB_KBC        = 4;
    localparam int          STB_MGMT       = 5;
    localparam logic [7:0]  STB_RO_MASK    = 8'h33;
    localparam logic [7:0]  STB_W1C_MASK   = 8'h0c;
    localparam logic [7:0]  EN_B_MASK      = 8'h3f;
    localparam logic [7:0]  BYTE_ZERO      = 8'h00;
    localparam logic [23:0] COUNT_RESET    = 24'h000000;
endpackage

// ==== rtl/pmt_sync.sv ====
// two-stage synchroniser with edge detect on the settled stage
`timescale 1ns/100ps
`default_nettype none
module pmt_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out,
    output logic      [WIDTH-1:0] rise_out,
    output logic      [WIDTH-1:0] toggle_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] prev_ff;
    logic [2:0]       arm_ff;

    initial begin
        if (WIDTH < 1) begin
            $error("pmt_sync width must be at least one");
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
            prev_ff <= '0;
            arm_ff  <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
            arm_ff  <= {arm_ff[1:0], 1'b1};
        end
    end

    // edges masked for three cycles after reset, until prev_ff also holds the pin, so reset makes no false edge
    assign sync_out   = sync_ff;
    assign rise_out   = sync_ff & ~prev_ff & {WIDTH{arm_ff[2]}};
    assign toggle_out = (sync_ff ^ prev_ff) & {WIDTH{arm_ff[2]}};
endmodule
`default_nettype wire

// ==== rtl/pmt_timer_sci.sv ====
// power-management timer read-out and sci status gathering
`timescale 1ns/100ps
`default_nettype none
module pmt_timer_sci #(
    parameter int CNT_W = pmt_pkg::COUNT_W
) (
    input  wire logic                        core_clk,
    input  wire logic                        reset_n,
    input  wire logic                        host_bus_reset,
    input  wire logic                        ref_clk_in,
    input  wire logic                        sys_working,
    input  wire logic                        pm_blk_sel,
    input  wire logic                        misc_block_base_sel,
    input  wire logic [pmt_pkg::ADDR_W-1:0]  io_addr,
    input  wire logic                        io_rd,
    input  wire logic                        io_wr,
    input  wire logic [pmt_pkg::BYTE_W-1:0]  io_wdata,
    output logic      [pmt_pkg::BYTE_W-1:0]  io_rdata,
    input  wire logic                        pm_rollover_sci_enable,
    input  wire logic                        pm_rollover_clear,
    output logic                             pm_rollover_flag,
    output logic                             pm_rollover_sci,
    input  wire logic                        disk_port_irq_status,
    input  wire logic                        printer_port_irq_status,
    input  wire logic                        second_serial_irq_status,
    input  wire logic                        first_serial_irq_status,
    input  wire logic                        floppy_irq_status,
    input  wire logic                        group_two_irq_status,
    input  wire logic                        group_one_irq_status,
    input  wire logic                        watchdog_irq_status,
    input  wire logic                        mouse_irq_status,
    input  wire logic                        keyboard_irq_status,
    input  wire logic                        kbc_port_line_status,
    input  wire logic                        mgmt_bus_irq_status,
    input  wire logic                        infrared_receive_alt,
    input  wire logic                        general_pin_alt,
    input  wire logic                        ir_pin_select,
    input  wire logic                        button_delay_start,
    input  wire logic                        sci_irq_route_en,
    output logic                             sci_group_out,
    output logic                             sci_irq_out
);
    import pmt_pkg::*;

    initial begin
        if (CNT_W <= BYTE_W || CNT_W > COUNT_W) begin
            $error("count width must lie between 9 and 24");
        end
        if (REF_DIV != (1 << REF_DIV_W)) begin
            $error("reference divider does not fit its counter");
        end
    end

    // ***************************
    // input synchronisers
    // ***************************
    localparam int N_IN = 17;

    logic [N_IN-1:0] pin_raw;
    logic [N_IN-1:0] pin_sync;
    logic [N_IN-1:0] pin_rise;
    logic [N_IN-1:0] pin_tgl;

    assign pin_raw = {general_pin_alt, infrared_receive_alt, ref_clk_in, sys_working,
                      host_bus_reset, mgmt_bus_irq_status, kbc_port_line_status,
                      keyboard_irq_status, mouse_irq_status, watchdog_irq_status,
                      group_one_irq_status, group_two_irq_status, floppy_irq_status,
                      first_serial_irq_status, second_serial_irq_status,
                      printer_port_irq_status, disk_port_irq_status};

    pmt_sync #(
        .WIDTH      (N_IN)
    ) u_sync (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .async_in   (pin_raw),
        .sync_out   (pin_sync),
        .rise_out   (pin_rise),
        .toggle_out (pin_tgl)
    );

    wire logic [7:0] src_a       = pin_sync[7:0];
    wire logic       src_mouse   = pin_sync[8];
    wire logic       src_kbd     = pin_sync[9];
    wire logic       src_kbc     = pin_sync[10];
    wire logic       src_mgmt    = pin_sync[11];
    wire logic       cnt_clr     = pin_sync[12];
    wire logic       working     = pin_sync[13];
    wire logic       ref_rise    = pin_rise[14];
    wire logic       ir_edge     = ir_pin_select ? pin_tgl[16] : pin_tgl[15];

    // ***************************
    // reference divider
    // ***************************
    logic [REF_DIV_W-1:0] div_ff;
    logic [REF_DIV_W-1:0] nxt_div;
    logic                 pm_tick;

    assign pm_tick = ref_rise && (div_ff == REF_DIV_W'(REF_DIV - 1));
    assign nxt_div = ref_rise ? div_ff + REF_DIV_W'(1) : div_ff;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end

    // ***************************
    // power-management count
    // ***************************
    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;
    wire logic [COUNT_W-1:0] count_full = COUNT_W'(count_ff);
    assign nxt_count = cnt_clr              ? CNT_W'(COUNT_RESET) :
                       (pm_tick && working) ? count_ff + CNT_W'(1) :
                                              count_ff;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_ff <= CNT_W'(COUNT_RESET);
        end else begin
            count_ff <= nxt_count;
        end
    end

    // ***************************
    // rollover flag
    // ***************************
    logic flag_ff;
    logic msb_change;

    assign msb_change = nxt_count[CNT_W-1] != count_ff[CNT_W-1];

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_ff <= 1'b0;
        end else if (msb_change) begin
            flag_ff <= 1'b1;
        end else if (pm_rollover_clear) begin
            flag_ff <= 1'b0;
        end
    end

    assign pm_rollover_flag = flag_ff;
    assign pm_rollover_sci  = flag_ff && pm_rollover_sci_enable;

    // ***************************
    // register decode
    // ***************************
    wire logic rd_cnt_low  = io_rd && pm_blk_sel && (io_addr == PM_CNT_LOW);
    wire logic rd_cnt_mid  = io_rd && pm_blk_sel && (io_addr == PM_CNT_MID);
    wire logic rd_cnt_up   = io_rd && pm_blk_sel && (io_addr == PM_CNT_UPPER);
    wire logic rd_cnt_sp   = io_rd && pm_blk_sel && (io_addr == PM_CNT_SPARE);
    wire logic rd_sts_a    = io_rd && misc_block_base_sel && (io_addr == SCI_STS_A);
    wire logic rd_sts_b    = io_rd && misc_block_base_sel && (io_addr == SCI_STS_B);
    wire logic rd_en_a     = io_rd && misc_block_base_sel && (io_addr == SCI_EN_A);
    wire logic rd_en_b     = io_rd && misc_block_base_sel && (io_addr == SCI_EN_B);
    wire logic wr_sts_b    = io_wr && misc_block_base_sel && (io_addr == SCI_STS_B);
    wire logic wr_en_a     = io_wr && misc_block_base_sel && (io_addr == SCI_EN_A);
    wire logic wr_en_b     = io_wr && misc_block_base_sel && (io_addr == SCI_EN_B);

    // ***************************
    // upper byte latch
    // ***************************
    logic [BYTE_W-1:0] mid_latch_ff;
    logic [BYTE_W-1:0] up_latch_ff;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mid_latch_ff <= BYTE_ZERO;
            up_latch_ff  <= BYTE_ZERO;
        end else if (rd_cnt_low) begin
            mid_latch_ff <= count_full[15:8];
            up_latch_ff  <= count_full[23:16];
        end
    end

    // ***************************
    // status b sticky bits and enables
    // ***************************
    logic ir_sts_ff;
    logic btn_sts_ff;
    logic [BYTE_W-1:0] en_a_ff;
    logic [BYTE_W-1:0] en_b_ff;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ir_sts_ff  <= 1'b0;
            btn_sts_ff <= 1'b0;
        end else begin
            if (ir_edge) begin
                ir_sts_ff <= 1'b1;
            end else if (wr_sts_b && io_wdata[STB_IR]) begin
                ir_sts_ff <= 1'b0;
            end
            if (button_delay_start) begin
                btn_sts_ff <= 1'b1;
            end else if (wr_sts_b && io_wdata[STB_BTN]) begin
                btn_sts_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            en_a_ff <= BYTE_ZERO;
            en_b_ff <= BYTE_ZERO;
        end else begin
            if (wr_en_a) begin
                en_a_ff <= io_wdata;
            end
            if (wr_en_b) begin
                en_b_ff <= io_wdata & EN_B_MASK;
            end
        end
    end

    logic [BYTE_W-1:0] sts_b;

    always_comb begin
        sts_b           = BYTE_ZERO;
        sts_b[STB_MOUSE] = src_mouse;
        sts_b[STB_KBD]   = src_kbd;
        sts_b[STB_IR]    = ir_sts_ff;
        sts_b[STB_BTN]   = btn_sts_ff;
        sts_b[STB_KBC]   = src_kbc;
        sts_b[STB_MGMT]  = src_mgmt;
    end

    // ***************************
    // group sci
    // ***************************
    wire logic grp_any = |(src_a & en_a_ff) || |(sts_b & en_b_ff);

    assign sci_group_out = grp_any;
    assign sci_irq_out   = grp_any && sci_irq_route_en;

    // ***************************
    // read data
    // ***************************
    logic [BYTE_W-1:0] rdata_ff;
    logic [BYTE_W-1:0] nxt_rdata;

    assign nxt_rdata = rd_cnt_low ? count_ff[7:0] :
                       rd_cnt_mid ? mid_latch_ff :
                       rd_cnt_up  ? up_latch_ff :
                       rd_cnt_sp  ? BYTE_ZERO :
                       rd_sts_a   ? src_a :
                       rd_sts_b   ? sts_b :
                       rd_en_a    ? en_a_ff :
                       rd_en_b    ? en_b_ff :
                                    BYTE_ZERO;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= BYTE_ZERO;
        end else if (io_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign io_rdata = rdata_ff;

    // ***************************
    // assertions
    // ***************************
    property p_count_step;
        @(posedge core_clk) disable iff (!reset_n)
        (pm_tick && working && !cnt_clr) |=> (count_ff == $past(count_ff) + CNT_W'(1));
    endproperty
    a_count_step: assert property (p_count_step) else $error("count did not advance");

    property p_count_clear;
        @(posedge core_clk) disable iff (!reset_n)
        cnt_clr |=> (count_ff == COUNT_RESET);
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("count not cleared");

    property p_count_hold;
        @(posedge core_clk) disable iff (!reset_n)
        (!ref_rise && !cnt_clr) |=> $stable(count_ff);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("count moved without ref");

    property p_roll_set;
        @(posedge core_clk) disable iff (!reset_n)
        (count_ff[CNT_W-1] != $past(count_ff[CNT_W-1])) |-> flag_ff;
    endproperty
    a_roll_set: assert property (p_roll_set) else $error("rollover flag not set");

    property p_roll_sci;
        @(posedge core_clk) disable iff (!reset_n)
        pm_rollover_sci == (pm_rollover_flag && pm_rollover_sci_enable);
    endproperty
    a_roll_sci: assert property (p_roll_sci) else $error("timer sci mismatch");

    property p_rd_mid;
        @(posedge core_clk) disable iff (!reset_n)
        rd_cnt_low ##2 rd_cnt_mid |=> (io_rdata == $past(count_full[15:8], 3));
    endproperty
    a_rd_mid: assert property (p_rd_mid) else $error("middle byte not coherent");

    property p_rd_up;
        @(posedge core_clk) disable iff (!reset_n)
        rd_cnt_low ##2 rd_cnt_up |=> (io_rdata == $past(count_full[23:16], 3));
    endproperty
    a_rd_up: assert property (p_rd_up) else $error("upper byte not coherent");

    property p_rd_spare;
        @(posedge core_clk) disable iff (!reset_n)
        rd_cnt_sp |=> (io_rdata == BYTE_ZERO);
    endproperty
    a_rd_spare: assert property (p_rd_spare) else $error("spare byte not zero");

    property p_latch;
        @(posedge core_clk) disable iff (!reset_n)
        rd_cnt_low |=> (up_latch_ff == $past(count_full[23:16])) &&
                       (mid_latch_ff == $past(count_full[15:8]));
    endproperty
    a_latch: assert property (p_latch) else $error("upper bytes not latched");

    property p_sts_a;
        @(posedge core_clk) disable iff (!reset_n)
        rd_sts_a |=> (io_rdata == $past(src_a));
    endproperty
    a_sts_a: assert property (p_sts_a) else $error("status a mismatch");

    property p_sts_b_src;
        @(posedge core_clk) disable iff (!reset_n)
        rd_sts_b |=> ((io_rdata & STB_RO_MASK) == ($past(sts_b) & STB_RO_MASK));
    endproperty
    a_sts_b_src: assert property (p_sts_b_src) else $error("status b mirror wrong");

    property p_ir_clear;
        @(posedge core_clk) disable iff (!reset_n)
        (wr_sts_b && io_wdata[STB_IR] && !ir_edge) |=> !ir_sts_ff;
    endproperty
    a_ir_clear: assert property (p_ir_clear) else $error("ir status not cleared");

    property p_ir_set;
        @(posedge core_clk) disable iff (!reset_n)
        ir_edge |=> ir_sts_ff;
    endproperty
    a_ir_set: assert property (p_ir_set) else $error("ir status not set");

    property p_btn_set;
        @(posedge core_clk) disable iff (!reset_n)
        button_delay_start |=> btn_sts_ff ##1 (btn_sts_ff || $past(wr_sts_b));
    endproperty
    a_btn_set: assert property (p_btn_set) else $error("button status not set");

    property p_rsvd;
        @(posedge core_clk) disable iff (!reset_n)
        rd_sts_b |=> (io_rdata[7:6] == 2'h0);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

    property p_irq_route;
        @(posedge core_clk) disable iff (!reset_n)
        !sci_irq_route_en |-> !sci_irq_out;
    endproperty
    a_irq_route: assert property (p_irq_route) else $error("irq routed while off");

    property p_group;
        @(posedge core_clk) disable iff (!reset_n)
        (en_a_ff == BYTE_ZERO && en_b_ff == BYTE_ZERO) |-> !sci_group_out;
    endproperty
    a_group: assert property (p_group) else $error("group sci without enable");
endmodule
`default_nettype wire

// ==== dv/pmt_host_model.sv ====
// host processor model issuing single-byte system i/o reads and writes
`timescale 1ns/100ps
`default_nettype none
module pmt_host_model (
    input  wire logic                       core_clk,
    output logic                            pm_blk_sel,
    output logic                            misc_block_base_sel,
    output logic [pmt_pkg::ADDR_W-1:0]      io_addr,
    output logic                            io_rd,
    output logic                            io_wr,
    output logic [pmt_pkg::BYTE_W-1:0]      io_wdata
);
    import pmt_pkg::*;
    initial begin
        pm_blk_sel  = 1'b0;
        misc_block_base_sel = 1'b0;
        io_addr     = 4'h0;
        io_rd       = 1'b0;
        io_wr       = 1'b0;
        io_wdata    = 8'h00;
    end
    // one strobe cycle, then the bus is released and shows inverted leftovers
    task automatic access(input logic pm, input logic [3:0] addr, input logic wr,
                          input logic [7:0] data);
        @(posedge core_clk);
        pm_blk_sel  <= pm;
        misc_block_base_sel <= ~pm;
        io_addr     <= addr;
        io_wdata    <= data;
        io_rd       <= ~wr;
        io_wr       <= wr;
        @(posedge core_clk);
        pm_blk_sel  <= 1'b0;
        misc_block_base_sel <= 1'b0;
        io_rd       <= 1'b0;
        io_wr       <= 1'b0;
        io_addr     <= ~addr;
        io_wdata    <= ~data;
    endtask
endmodule
`default_nettype wire

// ==== dv/test_pm_timer_sci_status.sv ====
// self-checking bench for the timer read-out and sci status block
`timescale 1ns/100ps
`default_nettype none
module test_pm_timer_sci_status;
    import pmt_pkg::*;
    localparam int TB_CNT_W = 10;
    logic       core_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       host_bus_reset = 1'b0;
    logic       ref_clk_in = 1'b0;
    logic       sys_working = 1'b1;
    logic       pm_blk_sel, misc_block_base_sel, io_rd, io_wr;
    logic [3:0] io_addr;
    logic [7:0] io_wdata, io_rdata, exp_n;
    logic       ro_en = 1'b0;
    logic       ro_clr = 1'b0;
    logic       ro_flag, ro_sci, group_out, irq_out;
    logic [7:0] src_a = 8'h00;
    logic [3:0] src_b = 4'h0;
    logic       ir_a = 1'b0;
    logic       ir_b = 1'b0;
    logic       ir_sel = 1'b0;
    logic       btn = 1'b0;
    logic       route = 1'b0;
    logic       rd_pend = 1'b0;
    logic [7:0] note_q[$];
    int         failures = 0;
    int         n_checks = 0;
    always #2 core_clk = ~core_clk;
    pmt_host_model i_pmt_host_model (.core_clk(core_clk), .pm_blk_sel(pm_blk_sel),
        .misc_block_base_sel(misc_block_base_sel), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
        .io_wdata(io_wdata));
    pmt_timer_sci #(.CNT_W(TB_CNT_W)) i_pmt_timer_sci (.core_clk(core_clk),
        .reset_n(reset_n), .host_bus_reset(host_bus_reset), .ref_clk_in(ref_clk_in),
        .sys_working(sys_working), .pm_blk_sel(pm_blk_sel), .misc_block_base_sel(misc_block_base_sel),
        .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .pm_rollover_sci_enable(ro_en), .pm_rollover_clear(ro_clr),
        .pm_rollover_flag(ro_flag), .pm_rollover_sci(ro_sci),
        .disk_port_irq_status(src_a[0]), .printer_port_irq_status(src_a[1]),
        .second_serial_irq_status(src_a[2]), .first_serial_irq_status(src_a[3]),
        .floppy_irq_status(src_a[4]), .group_two_irq_status(src_a[5]),
        .group_one_irq_status(src_a[6]), .watchdog_irq_status(src_a[7]),
        .mouse_irq_status(src_b[0]), .keyboard_irq_status(src_b[1]),
        .kbc_port_line_status(src_b[2]), .mgmt_bus_irq_status(src_b[3]),
        .infrared_receive_alt(ir_a), .general_pin_alt(ir_b), .ir_pin_select(ir_sel),
        .button_delay_start(btn), .sci_irq_route_en(route), .sci_group_out(group_out),
        .sci_irq_out(irq_out));
    // ***************************
    // checking helpers
    // ***************************
    task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask
    always @(posedge core_clk) begin
        if (rd_pend) begin
            exp_n = note_q.pop_front();
            check("io_rdata", exp_n, io_rdata);
        end
        rd_pend <= io_rd & (pm_blk_sel | misc_block_base_sel);
    end
    task automatic rd(input logic pm, input logic [3:0] a, input logic [7:0] e);
        note_q.push_back(e);
        i_pmt_host_model.access(pm, a, 1'b0, 8'h00);
    endtask
    task automatic wr(input logic pm, input logic [3:0] a, input logic [7:0] d);
        i_pmt_host_model.access(pm, a, 1'b1, d);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            cyc(3);
            ref_clk_in <= 1'b1;
            cyc(3);
            ref_clk_in <= 1'b0;
        end
        cyc(8);
    endtask
    function automatic logic [7:0] stb(input logic ir, input logic bt);
        return {2'b00, src_b[3], src_b[2], bt, ir, src_b[1], src_b[0]};
    endfunction
    task automatic wrap_up();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
    // ***************************
    // main sequence
    // ***************************
    initial begin
        void'($urandom(32'h8df6));
        cyc(20);
        reset_n <= 1'b1;
        rd(1'b1, PM_CNT_LOW, 8'h00);
        rd(1'b1, PM_CNT_UPPER, 8'h00);
        rd(1'b1, PM_CNT_SPARE, 8'h00);
        rd(1'b0, SCI_STS_B, 8'h00);
        $display("test reset done");
        pulses(16);
        rd(1'b1, PM_CNT_LOW, 8'h04);
        cyc(30);
        rd(1'b1, PM_CNT_LOW, 8'h04);
        sys_working <= 1'b0;
        pulses(16);
        rd(1'b1, PM_CNT_LOW, 8'h04);
        sys_working <= 1'b1;
        for (int a = 8; a < 12; a++) wr(1'b1, 4'(a), 8'hff);
        rd(1'b1, PM_CNT_LOW, 8'h04);
        rd(1'b1, PM_CNT_MID, 8'h00);
        $display("test count done");
        pulses(2028);
        check("pm_rollover_flag", 8'h00, {7'h00, ro_flag});
        ro_en <= 1'b1;
        rd(1'b1, PM_CNT_LOW, 8'hff);
        pulses(4);
        check("pm_rollover_flag", 8'h01, {7'h00, ro_flag});
        check("pm_rollover_sci", 8'h01, {7'h00, ro_sci});
        rd(1'b1, PM_CNT_MID, 8'h01);
        rd(1'b1, PM_CNT_UPPER, 8'h00);
        rd(1'b1, PM_CNT_LOW, 8'h00);
        rd(1'b1, PM_CNT_MID, 8'h02);
        ro_en <= 1'b0;
        cyc(2);
        check("pm_rollover_sci", 8'h00, {7'h00, ro_sci});
        ro_clr <= 1'b1;
        cyc(1);
        ro_clr <= 1'b0;
        cyc(2);
        check("pm_rollover_flag", 8'h00, {7'h00, ro_flag});
        pulses(2048);
        check("pm_rollover_flag", 8'h01, {7'h00, ro_flag});
        host_bus_reset <= 1'b1;
        cyc(6);
        host_bus_reset <= 1'b0;
        cyc(6);
        rd(1'b1, PM_CNT_LOW, 8'h00);
        $display("test rollover done");
        repeat (4) begin
            src_a <= 8'($urandom());
            src_b <= 4'($urandom());
            cyc(5);
            wr(1'b0, SCI_STS_A, 8'hff);
            wr(1'b0, SCI_STS_B, 8'hff);
            rd(1'b0, SCI_STS_A, src_a);
            rd(1'b0, SCI_STS_B, stb(1'b0, 1'b0));
        end
        $display("test status done");
        for (int s = 0; s < 2; s++) begin
            ir_sel <= s[0];
            cyc(4);
            if (s == 0) ir_b <= ~ir_b;
            else ir_a <= ~ir_a;
            cyc(6);
            rd(1'b0, SCI_STS_B, stb(1'b0, 1'b0));
            if (s == 0) ir_a <= ~ir_a;
            else ir_b <= ~ir_b;
            cyc(6);
            rd(1'b0, SCI_STS_B, stb(1'b1, 1'b0));
            wr(1'b0, SCI_STS_B, 8'hf3);
            rd(1'b0, SCI_STS_B, stb(1'b1, 1'b0));
            wr(1'b0, SCI_STS_B, 8'h04);
            rd(1'b0, SCI_STS_B, stb(1'b0, 1'b0));
        end
        btn <= 1'b1;
        cyc(1);
        btn <= 1'b0;
        rd(1'b0, SCI_STS_B, stb(1'b0, 1'b1));
        wr(1'b0, SCI_STS_B, 8'hf7);
        rd(1'b0, SCI_STS_B, stb(1'b0, 1'b1));
        wr(1'b0, SCI_STS_B, 8'h08);
        rd(1'b0, SCI_STS_B, stb(1'b0, 1'b0));
        btn <= 1'b1;
        ir_b <= ~ir_b;
        cyc(1);
        btn <= 1'b0;
        cyc(6);
        reset_n <= 1'b0;
        cyc(2);
        reset_n <= 1'b1;
        cyc(4);
        rd(1'b0, SCI_STS_B, stb(1'b0, 1'b0));
        $display("test ir button done");
        src_b <= 4'h0;
        for (int i = 0; i < 8; i++) begin
            src_a <= 8'h01 << i;
            wr(1'b0, SCI_EN_A, 8'h01 << ((i + 1) % 8));
            cyc(5);
            check("sci_group_out", 8'h00, {7'h00, group_out});
            wr(1'b0, SCI_EN_A, 8'h01 << i);
            route <= i[0];
            cyc(3);
            check("sci_group_out", 8'h01, {7'h00, group_out});
            check("sci_irq_out", {7'h00, i[0]}, {7'h00, irq_out});
        end
        rd(1'b0, SCI_EN_A, 8'h80);
        src_a <= 8'h00;
        src_b <= 4'h1;
        wr(1'b0, SCI_EN_B, 8'hc1);
        rd(1'b0, SCI_EN_B, 8'h01);
        cyc(5);
        check("sci_group_out", 8'h01, {7'h00, group_out});
        $display("test group done");
        cyc(4);
        wrap_up();
    end
endmodule
`default_nettype wire
